// ===== rtl/asfrc_top.sv
// Purpose: protection and reset control of a four half-bridge power stage
// Assumes: 10 MHz clk_i; nrst_i is the power-on clear
// Notes: hb_enable_o bit set lets that half-bridge switch
//
// Notes on behaviour
// - any supply low: all half-bridges hi-z at once, fault output low one cycle later.
// - all supplies good again: switching resumes without reset activity.
// - power-on clears overload latch; outputs held off until ready.
// - pair one reset low forces half-bridges A and B hi-z.
// - pair two reset low forces half-bridges C and D hi-z.
// - bridged mode: weak pulldown on pair outputs while its reset low.
// - single-ended mode: weak pulldowns stay off always.
// - either reset low forces fault output high.
// - reset rising edge clears latched overload, switching resumes.
// - overload latches shutdown of only the offending pair.
// - either reset asserted clears overtemperature latch.
`default_nettype none
module asfrc_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pair_one_reset_n_i,
  input wire logic pair_two_reset_n_i,
  input wire logic gate_drive_supply_ok_i,
  input wire logic core_supply_ok_i,
  input wire logic overload_pair_one_i,
  input wire logic overload_pair_two_i,
  input wire logic overtemp_i,
  input wire logic single_ended_mode_i,
  output logic [asfrc_pkg::NUM_HB-1:0] hb_enable_o,
  output logic [asfrc_pkg::NUM_HB-1:0] weak_pulldown_o,
  output logic fault_out_n_o,
  output logic [1:0] overload_latch_o,
  output logic overtemp_error_latch_o,
  output logic supply_low_guard_o
);
  import asfrc_pkg::*;

  logic p1_lvl_n;
  logic p1_rise;
  logic p2_lvl_n;
  logic p2_rise;
  logic sup_meta_q;
  logic sup_ok_q;
  logic [2:0] flt_meta_q;
  logic [2:0] flt_q;
  asfrc_por_state_t por_q;
  logic [POR_CNT_W-1:0] por_cnt_q;
  logic ready;
  logic [1:0] ovl_q;
  logic ote_q;
  logic [1:0] pair_off;
  logic [1:0] pair_rst;
  logic fault_n_d;
  logic fault_n_q;
  logic [NUM_HB-1:0] en_q;
  logic [NUM_HB-1:0] wpd_q;

  function automatic logic [NUM_HB-1:0] pair_to_hb(input logic [1:0] p);
    pair_to_hb = {p[1], p[1], p[0], p[0]};
  endfunction : pair_to_hb

  asfrc_reset_sync u_sync_one (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_n_i(pair_one_reset_n_i),
    .level_n_o(p1_lvl_n),
    .rise_o(p1_rise)
  );

  asfrc_reset_sync u_sync_two (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_n_i(pair_two_reset_n_i),
    .level_n_o(p2_lvl_n),
    .rise_o(p2_rise)
  );

  // supply and fault detectors are analog, so synchronise them
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sup_meta_q <= 1'b0;
      sup_ok_q <= 1'b0;
      flt_meta_q <= 3'h0;
      flt_q <= 3'h0;
    end else begin
      sup_meta_q <= gate_drive_supply_ok_i & core_supply_ok_i;
      sup_ok_q <= sup_meta_q;
      flt_meta_q <= {overtemp_i, overload_pair_two_i, overload_pair_one_i};
      flt_q <= flt_meta_q;
    end
  end

  // power-on clear, then settle before release
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_q <= ASFRC_POR_CLEAR;
      por_cnt_q <= '0;
    end else begin
      unique case (por_q)
        ASFRC_POR_CLEAR: begin
          por_q <= ASFRC_POR_SETTLE;
          por_cnt_q <= '0;
        end
        ASFRC_POR_SETTLE: begin
          if (por_cnt_q == POR_CNT_W'(POR_SETTLE_CYC - 1)) begin
            por_q <= ASFRC_POR_READY;
          end else begin
            por_cnt_q <= por_cnt_q + POR_CNT_W'(1);
          end
        end
        ASFRC_POR_READY: begin
          por_q <= ASFRC_POR_READY;
        end
        default: begin
          por_q <= ASFRC_POR_CLEAR;
        end
      endcase
    end
  end

  assign ready = (por_q == ASFRC_POR_READY);
  assign pair_rst = {~p2_lvl_n, ~p1_lvl_n};

  // overload latch per pair; a new overload beats a coincident clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovl_q <= PAIRS_NONE;
    end else if (por_q == ASFRC_POR_CLEAR) begin
      ovl_q <= PAIRS_NONE;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ready && flt_q[i]) begin
          ovl_q[i] <= 1'b1;
        end else if (p1_rise || p2_rise) begin
          ovl_q[i] <= 1'b0;
        end
      end
    end
  end

  // overtemp latch, cleared while a reset is held low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ote_q <= 1'b0;
    end else if (ready && flt_q[2]) begin
      ote_q <= 1'b1;
    end else if (pair_rst != PAIRS_NONE) begin
      ote_q <= 1'b0;
    end
  end

  always_comb begin
    pair_off = pair_rst | ovl_q;
    if (!sup_ok_q || !ready || ote_q) begin
      pair_off = PAIRS_ALL;
    end
    fault_n_d = 1'b1;
    if (!sup_ok_q || ote_q || (ovl_q != PAIRS_NONE)) begin
      fault_n_d = 1'b0;
    end
    if (pair_rst != PAIRS_NONE) begin
      fault_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_q <= '0;
      fault_n_q <= 1'b1;
    end else begin
      en_q <= ~pair_to_hb(pair_off);
      fault_n_q <= fault_n_d;
    end
  end

  // pulldown only in bridged mode; single-ended relies on PWM low pulse
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wpd_q <= '0;
    end else if (single_ended_mode_i) begin
      wpd_q <= '0;
    end else begin
      wpd_q <= pair_to_hb(pair_rst);
    end
  end

  // the supply guard acts combinationally so hi-z is not delayed a cycle
  assign hb_enable_o = en_q & {NUM_HB{sup_ok_q}};
  assign weak_pulldown_o = wpd_q;
  assign fault_out_n_o = fault_n_q;
  assign overload_latch_o = ovl_q;
  assign overtemp_error_latch_o = ote_q;
  assign supply_low_guard_o = ~sup_ok_q;
endmodule : asfrc_top
`default_nettype wire

// ===== rtl/asfrc_pkg.sv
// Purpose: shared constants for the amp stage fault and reset control
// Assumes: 10 MHz clk_i
// Notes: half-bridge index 0..3 is A..D
`default_nettype none
package asfrc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned NUM_HB = 4;
  localparam int unsigned SYNC_STAGES = 2;
  // settle time before outputs are released after power-on clear
  localparam int unsigned POR_SETTLE_US = 10;
  localparam int unsigned POR_SETTLE_CYC =
    (POR_SETTLE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    POR_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned POR_CNT_W = $clog2(POR_SETTLE_CYC + 1);
  localparam logic [1:0] PAIR_ONE_MASK = 2'h1;
  localparam logic [1:0] PAIR_TWO_MASK = 2'h2;
  localparam logic [1:0] PAIRS_NONE = 2'h0;
  localparam logic [1:0] PAIRS_ALL = 2'h3;
  typedef enum logic [1:0] {
    ASFRC_POR_CLEAR,
    ASFRC_POR_SETTLE,
    ASFRC_POR_READY
  } asfrc_por_state_t;
endpackage : asfrc_pkg
`default_nettype wire

// ===== rtl/asfrc_reset_sync.sv
// Purpose: synchronise one reset pin and flag its rising edge
// Assumes: input is asynchronous to clk_i
// Notes: first stage is read only by the second stage
`default_nettype none
module asfrc_reset_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pin_n_i,
  output logic level_n_o,
  output logic rise_o
);
  import asfrc_pkg::*;
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_n_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_n_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
endmodule : asfrc_reset_sync
`default_nettype wire

// ===== testbench/asfrc_sva.sv
// Purpose: port checker for asfrc_top
// Assumes: nrst_i low disables checks
// Notes: delays allow for the two-flop sync
`default_nettype none
module asfrc_sva (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pair_one_reset_n_i,
  input wire logic pair_two_reset_n_i,
  input wire logic gate_drive_supply_ok_i,
  input wire logic core_supply_ok_i,
  input wire logic single_ended_mode_i,
  input wire logic [asfrc_pkg::NUM_HB-1:0] hb_enable_o,
  input wire logic [asfrc_pkg::NUM_HB-1:0] weak_pulldown_o,
  input wire logic fault_out_n_o,
  input wire logic [1:0] overload_latch_o,
  input wire logic supply_low_guard_o
);
  import asfrc_pkg::*;
  logic [6:0] up_q;
  wire logic ok = gate_drive_supply_ok_i && core_supply_ok_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // cycles since power-on clear, saturating
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) up_q <= 7'h00;
    else if (up_q != 7'h7F) up_q <= up_q + 7'h01;
  end
  a_supply_off: assert property ((!ok) [*2] |=>
    hb_enable_o == 4'h0 && supply_low_guard_o) else $error("supply off");
  a_supply_resume: assert property (ok [*3] |=>
    !supply_low_guard_o) else $error("supply resume");
  a_por_hold: assert property (up_q < 7'h64 |->
    hb_enable_o == 4'h0 && overload_latch_o == 2'h0) else $error("por");
  a_pair_one_mute: assert property ((!pair_one_reset_n_i) [*3] |=>
    hb_enable_o[1:0] == 2'h0) else $error("pair one mute");
  a_pair_two_mute: assert property ((!pair_two_reset_n_i) [*3] |=>
    hb_enable_o[3:2] == 2'h0) else $error("pair two mute");
  a_weak_pull_on: assert property (
    (!pair_one_reset_n_i && !single_ended_mode_i) [*3] |=>
    weak_pulldown_o[1:0] == 2'h3) else $error("pulldown on");
  a_se_pull_off: assert property (single_ended_mode_i [*3] |=>
    weak_pulldown_o == 4'h0) else $error("pulldown off");
  a_fault_forced: assert property (
    (!pair_one_reset_n_i || !pair_two_reset_n_i) [*3] |=> fault_out_n_o)
    else $error("fault forced");
  c_fault: cover property ($fell(fault_out_n_o));
  c_overload: cover property (overload_latch_o == 2'h1);
  c_release: cover property ($rose(pair_one_reset_n_i));
endmodule : asfrc_sva
bind asfrc_top asfrc_sva u_asfrc_sva (.*);
`default_nettype wire

// ===== testbench/asfrc_ctrl_model.sv
// Purpose: controller that drives both reset pins
// Assumes: bench gives wanted levels, bit 0 is pair one
// Notes: HOLD_CYC is a shortened stand-in for the 4 ms wait
`default_nettype none
module asfrc_ctrl_model #(parameter int HOLD_CYC = 8) (
  input wire logic clk_i,
  input wire logic fault_out_n_i,
  input wire logic [1:0] want_n_i,
  output logic [1:0] reset_n_o = 2'h3
);
  timeunit 1ns;
  timeprecision 1ns;
  int since = HOLD_CYC;
  logic flt_q = 1'b1;
  always @(posedge clk_i) begin
    since <= (flt_q && !fault_out_n_i) ? 0 : since + 1;
    flt_q <= fault_out_n_i;
    for (int i = 0; i < 2; i++) begin
      if (!want_n_i[i]) reset_n_o[i] <= 1'b0;
      else if (since >= HOLD_CYC) reset_n_o[i] <= 1'b1;
    end
  end
endmodule : asfrc_ctrl_model
`default_nettype wire

// ===== testbench/asfrc_top_tb_top.sv
// Purpose: self-checking bench for asfrc_top
// Assumes: reset pins come through the controller model
// Notes: row = {want1,want2,gd,core,ov1,ov2,ot,se, hb,pd,fault_n}
`default_nettype none
module asfrc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import asfrc_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] in_q = 8'hF0;
  logic [1:0] rst_n;
  logic [NUM_HB-1:0] hb, pd;
  logic flt_n, ot_l, slg;
  logic [1:0] ol;
  int err_count = 0;
  int samples_checked = 0;
  logic [16:0] row [20] = '{17'h1E1E1, 17'h0E187, 17'h0601F, 17'h1E1E1,
    17'h1A000, 17'h1C000, 17'h1E1E1, 17'h1F180, 17'h1E180, 17'h0E187,
    17'h1E1E1, 17'h1E860, 17'h16079, 17'h1E1E1, 17'h1E400, 17'h1E000,
    17'h0E187, 17'h1E1E1, 17'h0E381, 17'h1E3E1};
  asfrc_ctrl_model u_asfrc_ctrl_model (.clk_i(clk_i), .fault_out_n_i(flt_n),
    .want_n_i({in_q[6], in_q[7]}), .reset_n_o(rst_n));
  asfrc_top u_asfrc_top (.clk_i(clk_i), .nrst_i(nrst_i),
    .pair_one_reset_n_i(rst_n[0]), .pair_two_reset_n_i(rst_n[1]),
    .gate_drive_supply_ok_i(in_q[5]), .core_supply_ok_i(in_q[4]),
    .overload_pair_one_i(in_q[3]), .overload_pair_two_i(in_q[2]),
    .overtemp_i(in_q[1]), .single_ended_mode_i(in_q[0]),
    .hb_enable_o(hb), .weak_pulldown_o(pd), .fault_out_n_o(flt_n),
    .overload_latch_o(ol), .overtemp_error_latch_o(ot_l),
    .supply_low_guard_o(slg));
  task automatic chk(input string nm, input logic [8:0] ex,
    input logic [8:0] got);
    samples_checked++;
    if (got !== ex) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial forever #50 clk_i = ~clk_i;
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (50) @(negedge clk_i);
    chk("por hb", 9'h000, {5'h00, hb});
    repeat (70) @(negedge clk_i);
    foreach (row[i]) begin
      in_q = row[i][16:9];
      repeat (16) @(negedge clk_i);
      chk($sformatf("row %0d", i), row[i][8:0], {hb, pd, flt_n});
      $display("row %0d done", i);
    end
    // clear while an overload is latched, input still high
    in_q = 8'hF8;
    repeat (16) @(negedge clk_i);
    nrst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    in_q = 8'hF0;
    repeat (16) @(negedge clk_i);
    chk("por mid", 9'h000, {5'h00, hb, ol, ot_l});
    repeat (110) @(negedge clk_i);
    chk("por end", 9'h00F, {5'h00, hb});
    $display("power-on clear test done");
    give_verdict();
  end
endmodule : asfrc_top_tb_top
`default_nettype wire
